// ### discharge_off_pin_config.sv
// Discharge-off pin configuration with AHB-Lite register access
// What this block does
// - Selector 0 unused, 1 general output, 2 FET-off control, 3 analog input.
// - The six option bits mean different things per selected function.
// - Option 5 sets control polarity, high or low; ignored for general output.
// - Option 4 picks discharge-only or both-FETs off control.
// - Option 3 picks 1.8 V rail or regulator rail for high drive.
// - Option 2 enables weak pull-up to regulator rail.
// - Option 1 picks tri-state or active high drive; option 3 set forces active drive.
// - Option 0 enables weak pull-down to ground.
// - Analog options 5:4 pick 18k, 180k or no pull-up.
// - Analog options 3:2 pick 18K, 180K, custom or raw conversion.
// - Analog options 1:0 pick measurement use and protection target.
// - Setup byte resets to zero, pin unused.
`timescale 1ns/10ps
module discharge_off_pin_config
  import pin_cfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic rail_programmable_regulator_rail_out,
  output logic weak_pullup_out,
  output logic weak_pulldown_out,
  output logic pullup_18k_out,
  output logic pullup_180k_out,
  output logic analog_sel_out,
  output logic [1:0] temp_model_out,
  output logic [1:0] meas_type_out,
  output logic dsg_fet_off_out,
  output logic chg_fet_off_out
);
  pin_cfg_if cfg ();

  logic [7:0] setup;
  logic [7:0] next_setup;
  logic gpo_level;
  logic next_gpo_level;
  logic wr_pend;
  logic next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic access;
  logic next_pin_out;
  logic next_pin_oe;
  logic next_dsg_off;
  logic next_chg_off;
  logic next_ctrl_active;
  logic [7:0] next_status;

  assign cfg.setup = setup;

  pin_option_decode u_decode (
    .cfg(cfg)
  );

  function automatic logic [31:0] read_mux(input logic [11:0] addr, input logic [7:0] su,
                                           input logic lvl, input logic [7:0] st);
    logic [31:0] d;
    d = RDATA_RESET;
    if (addr == OFF_PIN_SETUP) begin
      d[7:0] = su;
    end else if (addr == OFF_DRIVE) begin
      d[0] = lvl;
    end else if (addr == OFF_STATUS) begin
      d[7:0] = st;
    end
    return d;
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  always_comb begin
    access = hsel_in & htrans_in[1] & hready_in;
    next_wr_pend = access & hwrite_in;
    next_wr_addr = access ? haddr_in[11:0] : wr_addr;
    next_setup = setup;
    next_gpo_level = gpo_level;
    if (wr_pend && wr_addr == OFF_PIN_SETUP) begin
      next_setup = hwdata_in[7:0];
    end
    if (wr_pend && wr_addr == OFF_DRIVE) begin
      next_gpo_level = hwdata_in[0];
    end
    next_status = 8'h00;
    next_status[1:0] = setup[FUNC_LSB +: 2];
    next_status[ST_PIN_LEVEL] = pin_in;
    next_status[ST_CTRL_ACTIVE] = next_ctrl_active;
    next_status[ST_DSG_OFF] = next_dsg_off;
    next_status[ST_CHG_OFF] = next_chg_off;
    next_status[ST_CONFLICT] = cfg.conflict;
    // Read data built from post-edge values so a write just before reads back
    next_hrdata = (access && !hwrite_in) ?
                  read_mux(haddr_in[11:0], next_setup, next_gpo_level, next_status) : RDATA_RESET;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      setup <= PIN_SETUP_RESET;
      gpo_level <= DRIVE_RESET;
      wr_pend <= 1'b0;
      wr_addr <= OFF_PIN_SETUP;
      hrdata_out <= RDATA_RESET;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      setup <= next_setup;
      gpo_level <= next_gpo_level;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata_out <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // ****************************************
  // Pin behaviour
  // ****************************************
  always_comb begin
    next_ctrl_active = cfg.ctrl_mode & (pin_in ^ cfg.active_low);
    // Both variant also drops charge FET
    next_dsg_off = next_ctrl_active;
    next_chg_off = next_ctrl_active & cfg.both_off;
    next_pin_out = 1'b0;
    next_pin_oe = 1'b0;
    if (cfg.gpo_mode) begin
      next_pin_out = gpo_level;
      next_pin_oe = ~gpo_level | cfg.drive_high;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      rail_programmable_regulator_rail_out <= 1'b0;
      weak_pullup_out <= 1'b0;
      weak_pulldown_out <= 1'b0;
      pullup_18k_out <= 1'b0;
      pullup_180k_out <= 1'b0;
      analog_sel_out <= 1'b0;
      temp_model_out <= 2'h0;
      meas_type_out <= 2'h0;
      dsg_fet_off_out <= 1'b0;
      chg_fet_off_out <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_out <= next_pin_oe;
      rail_programmable_regulator_rail_out <= cfg.rail_programmable_regulator_rail & cfg.gpo_mode;
      weak_pullup_out <= cfg.weak_pu;
      weak_pulldown_out <= cfg.weak_pd;
      pullup_18k_out <= cfg.pu_18k;
      pullup_180k_out <= cfg.pu_180k;
      analog_sel_out <= cfg.analog_mode;
      temp_model_out <= cfg.temp_model;
      meas_type_out <= cfg.meas_type;
      dsg_fet_off_out <= next_dsg_off;
      chg_fet_off_out <= next_chg_off;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_unused_quiet: assert property (
    (setup[1:0] == 2'h0) |=> (!pin_oe_out && !analog_sel_out && !dsg_fet_off_out && !weak_pullup_out))
    else $error("unused pin not quiet");

  a_option_per_func: assert property (
    (setup[1:0] == 2'h2) |=> (!pullup_18k_out && !pullup_180k_out && temp_model_out == 2'h0))
    else $error("analog options leaked into control mode");

  a_ctrl_polarity: assert property (
    (setup[1:0] == 2'h2) |=> (dsg_fet_off_out == ($past(pin_in) ^ $past(setup[7]))))
    else $error("control polarity wrong");

  a_both_off_variant: assert property (
    dsg_fet_off_out |-> (chg_fet_off_out == $past(setup[6])))
    else $error("both-off variant wrong");

  a_rail_select: assert property (
    (setup[1:0] == 2'h1) |=> (rail_programmable_regulator_rail_out == $past(setup[5])))
    else $error("rail select wrong");

  a_weak_pullup: assert property (
    (setup[1:0] == 2'h1 || setup[1:0] == 2'h2) |=> (weak_pullup_out == $past(setup[4])))
    else $error("weak pull-up wrong");

  a_gpo_tristate: assert property (
    (setup[1:0] == 2'h1 && gpo_level && !setup[3] && !setup[5]) |=> (!pin_oe_out ##1 1'b1))
    else $error("high level not released");

  a_gpo_drive: assert property (
    (setup[1:0] == 2'h1 && (setup[3] || setup[5] || !gpo_level)) |=> (pin_oe_out && pin_out == $past(gpo_level)))
    else $error("pin not driven");

  a_weak_pulldown: assert property (
    (setup[1:0] == 2'h2) |=> (weak_pulldown_out == $past(setup[2])))
    else $error("weak pull-down wrong");

  a_analog_pullup: assert property (
    (setup[1:0] == 2'h3 && setup[7:6] == 2'h0) |=> (pullup_18k_out && !pullup_180k_out && !pin_oe_out))
    else $error("18k pull-up not selected");

  a_reserved_pullup: assert property (
    (setup[1:0] == 2'h3 && setup[7:6] == 2'h3) |=> (!pullup_18k_out && !pullup_180k_out))
    else $error("reserved pull-up code applied a pull-up");

  a_temp_model: assert property (
    (setup[1:0] == 2'h3) |=> (temp_model_out == $past(setup[5:4]) && analog_sel_out))
    else $error("temperature model wrong");

  a_meas_type: assert property (
    (setup[1:0] == 2'h3) |=> (meas_type_out == $past(setup[3:2])))
    else $error("measurement type wrong");

  a_reset_default: assert property (
    $rose(rst_b_in) |-> (setup == 8'h00 && !pin_oe_out))
    else $error("setup not zero after reset");

  a_write_setup: assert property (
    (wr_pend && wr_addr == OFF_PIN_SETUP) |=> (setup == $past(hwdata_in[7:0])))
    else $error("setup write did not land");

  a_read_setup: assert property (
    (access && !hwrite_in && haddr_in[11:0] == OFF_PIN_SETUP) |=> (hrdata_out == {24'h00_0000, setup}))
    else $error("setup read data wrong");

  a_write_drive: assert property (
    (wr_pend && wr_addr == OFF_DRIVE) |=> (gpo_level == $past(hwdata_in[0])))
    else $error("drive write did not land");

  a_read_idle: assert property (
    !(access && !hwrite_in) |=> (hrdata_out == RDATA_RESET))
    else $error("read data outside read phase");

  a_gpo_no_control: assert property (
    (setup[1:0] == 2'h1) |=> (!dsg_fet_off_out && !chg_fet_off_out))
    else $error("control acted in general output");

  a_ctrl_no_drive: assert property (
    (setup[1:0] == 2'h2) |=> (!pin_oe_out && !rail_programmable_regulator_rail_out))
    else $error("control input driven");

  a_dsg_only_variant: assert property (
    (setup[1:0] == 2'h2 && !setup[6]) |=> !chg_fet_off_out)
    else $error("charge FET off in discharge-only variant");

  a_rail_gpo_only: assert property (
    (setup[1:0] != 2'h1) |=> !rail_programmable_regulator_rail_out)
    else $error("rail select outside general output");

  a_gpo_forced_high: assert property (
    (setup[1:0] == 2'h1 && setup[5]) |=> pin_oe_out)
    else $error("regulator rail high level released");

  a_gpo_pulldown: assert property (
    (setup[1:0] == 2'h1) |=> (weak_pulldown_out == $past(setup[2])))
    else $error("general output pull-down wrong");

  a_analog_180k: assert property (
    (setup[1:0] == 2'h3 && setup[7:6] == 2'h1) |=> (pullup_180k_out && !pullup_18k_out))
    else $error("180k pull-up not selected");

  a_analog_no_pull: assert property (
    (setup[1:0] == 2'h3 && setup[7:6] == 2'h2) |=> (!pullup_18k_out && !pullup_180k_out))
    else $error("plain analog input has a pull-up");

  a_analog_no_drive: assert property (
    (setup[1:0] == 2'h3) |=> (!pin_oe_out && !weak_pullup_out && !weak_pulldown_out && !dsg_fet_off_out))
    else $error("digital options leaked into analog mode");

  a_non_analog_fields: assert property (
    (setup[1:0] != 2'h3) |=> (temp_model_out == 2'h0 && meas_type_out == 2'h0 && !analog_sel_out))
    else $error("analog fields set outside analog mode");

  c_gpo_high: cover property (setup[1:0] == 2'h1 && gpo_level ##1 pin_oe_out && pin_out);
  c_both_off: cover property (dsg_fet_off_out && chg_fet_off_out);
  c_analog_raw: cover property (analog_sel_out && temp_model_out == 2'h3);
  c_ctrl_active_low: cover property (setup[1:0] == 2'h2 && setup[7] && !pin_in ##1 dsg_fet_off_out);
  c_write_read: cover property (wr_pend && wr_addr == OFF_PIN_SETUP ##1 access && !hwrite_in);
endmodule // discharge_off_pin_config

// ### pin_cfg_pkg.sv
// Constants and types for the discharge-off pin configuration block
package pin_cfg_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFF_PIN_SETUP = 12'h000;
  localparam logic [11:0] OFF_DRIVE = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [7:0] PIN_SETUP_RESET = 8'h00;
  localparam logic DRIVE_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int FUNC_LSB = 0;
  localparam int OPT_LSB = 2;
  localparam int OPT_POLARITY = 5;
  localparam int OPT_BOTH_OFF = 4;
  localparam int OPT_RAIL = 3;
  localparam int OPT_PULLUP = 2;
  localparam int OPT_DRIVE_HIGH = 1;
  localparam int OPT_PULLDOWN = 0;
  localparam int ST_PIN_LEVEL = 2;
  localparam int ST_CTRL_ACTIVE = 3;
  localparam int ST_DSG_OFF = 4;
  localparam int ST_CHG_OFF = 5;
  localparam int ST_CONFLICT = 6;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    FUNC_UNUSED = 2'h0,
    FUNC_GENERAL_OUTPUT = 2'h1,
    FUNC_FET_OFF_CONTROL = 2'h2,
    FUNC_ANALOG_INPUT = 2'h3
  } pin_func_t;
  localparam logic [1:0] PULLUP_18K = 2'h0;
  localparam logic [1:0] PULLUP_180K = 2'h1;
  localparam logic [1:0] PULLUP_NONE = 2'h2;
  localparam logic [1:0] PULLUP_RESERVED = 2'h3;
endpackage

// ### pin_cfg_if.sv
// Decoded pin configuration passed from the decoder to the top
`timescale 1ns/10ps
interface pin_cfg_if;
  import pin_cfg_pkg::*;
  logic [7:0] setup;
  pin_func_t func;
  logic gpo_mode;
  logic ctrl_mode;
  logic analog_mode;
  logic active_low;
  logic both_off;
  logic rail_programmable_regulator_rail;
  logic weak_pu;
  logic drive_high;
  logic weak_pd;
  logic pu_18k;
  logic pu_180k;
  logic [1:0] temp_model;
  logic [1:0] meas_type;
  logic conflict;
  modport decoder (
    input setup,
    output func, gpo_mode, ctrl_mode, analog_mode, active_low, both_off, rail_programmable_regulator_rail,
    output weak_pu, drive_high, weak_pd, pu_18k, pu_180k, temp_model, meas_type, conflict
  );
  modport user (
    output setup,
    input func, gpo_mode, ctrl_mode, analog_mode, active_low, both_off, rail_programmable_regulator_rail,
    input weak_pu, drive_high, weak_pd, pu_18k, pu_180k, temp_model, meas_type, conflict
  );
endinterface

// ### pin_option_decode.sv
// Function-dependent decoding of the pin setup byte
`timescale 1ns/10ps
module pin_option_decode
  import pin_cfg_pkg::*;
(
  pin_cfg_if.decoder cfg
);
  logic [5:0] opt;
  logic digital;

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    opt = cfg.setup[OPT_LSB +: 6];
    cfg.func = pin_func_t'(cfg.setup[FUNC_LSB +: 2]);
    cfg.gpo_mode = (cfg.func == FUNC_GENERAL_OUTPUT);
    cfg.ctrl_mode = (cfg.func == FUNC_FET_OFF_CONTROL);
    cfg.analog_mode = (cfg.func == FUNC_ANALOG_INPUT);
    digital = cfg.gpo_mode | cfg.ctrl_mode;
    cfg.active_low = cfg.ctrl_mode & opt[OPT_POLARITY];
    cfg.both_off = cfg.ctrl_mode & opt[OPT_BOTH_OFF];
    cfg.rail_programmable_regulator_rail = digital & opt[OPT_RAIL];
    cfg.weak_pu = digital & opt[OPT_PULLUP];
    cfg.drive_high = opt[OPT_DRIVE_HIGH] | opt[OPT_RAIL];
    cfg.weak_pd = digital & opt[OPT_PULLDOWN];
    cfg.pu_18k = cfg.analog_mode & (opt[5:4] == PULLUP_18K);
    cfg.pu_180k = cfg.analog_mode & (opt[5:4] == PULLUP_180K);
    cfg.temp_model = cfg.analog_mode ? opt[3:2] : 2'h0;
    cfg.meas_type = cfg.analog_mode ? opt[1:0] : 2'h0;
    // Software-advised combinations flagged, not blocked
    cfg.conflict = digital & opt[OPT_RAIL] & (opt[OPT_PULLUP] | ~opt[OPT_DRIVE_HIGH]);
  end
endmodule // pin_option_decode

// ### pin_partner.sv
// External pin circuitry: host drive, weak pulls and a floating wire
`timescale 1ns/10ps
module pin_partner (
  input wire logic core_clk_in,
  input wire logic drive_in,
  input wire logic oe_in,
  input wire logic pullup_in,
  input wire logic pulldown_in,
  input wire logic ext_en_in,
  input wire logic ext_val_in,
  output logic level_out
);
  logic float_val = 1'b0;
  // Undriven wire changes every cycle, no stable guess
  always @(posedge core_clk_in) float_val <= ~float_val;
  // Tri-state leaves the wire to others
  always_comb begin
    if (oe_in) level_out = drive_in;
    else if (ext_en_in) level_out = ext_val_in;
    else if (pullup_in) level_out = 1'b1;
    else if (pulldown_in) level_out = 1'b0;
    else level_out = float_val;
  end
endmodule // pin_partner

// ### discharge_off_pin_config_tb.sv
// Self-checking bench for the discharge-off pin configuration block
`timescale 1ns/10ps
module discharge_off_pin_config_tb;
  import pin_cfg_pkg::*;
  logic clk = 1'b0, rst_b, hsel, hwrite, ext_val, ext_en, pin_w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v, seed;
  logic hready, hresp, pin_o, pin_oe, rail, wpu, wpd, pu18, pu180, asel, dsg, chg;
  logic [1:0] tm, mt;
  logic [7:0] q[$] = '{8'h02, 8'hA2, 8'h92, 8'h05, 8'h21, 8'hF3, 8'h83, 8'h43, 8'h3F, 8'h6E, 8'h00};
  int num_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  discharge_off_pin_config discharge_off_pin_config_i (.core_clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .pin_in(pin_w),
    .pin_out(pin_o), .pin_oe_out(pin_oe), .rail_programmable_regulator_rail_out(rail), .weak_pullup_out(wpu),
    .weak_pulldown_out(wpd), .pullup_18k_out(pu18), .pullup_180k_out(pu180), .analog_sel_out(asel),
    .temp_model_out(tm), .meas_type_out(mt), .dsg_fet_off_out(dsg), .chg_fet_off_out(chg));
  pin_partner pin_partner_i (.core_clk_in(clk), .drive_in(pin_o), .oe_in(pin_oe), .pullup_in(wpu),
    .pulldown_in(wpd), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_w));
  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d errors", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin num_errors++; report_and_stop(); end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {20'h0_0000, a}; hwrite <= w;
    wait_ready();
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  // ****************************************
  // Reference model of the decoded outputs
  // ****************************************
  function automatic logic [15:0] model(input logic [7:0] s, input logic drv, input logic lvl);
    logic [15:0] e;
    logic [5:0] o;
    e = '0; o = s[7:2];
    case (s[1:0])
      2'h1: begin e[15] = drv ? (o[1] | o[3]) : 1'b1; e[14] = drv; e[13] = o[3]; e[12] = o[2]; e[11] = o[0]; end
      2'h2: begin e[12] = o[2]; e[11] = o[0]; e[1] = lvl ^ o[5]; e[0] = (lvl ^ o[5]) & o[4]; end
      2'h3: begin
        e[10] = (o[5:4] == 2'h0); e[9] = (o[5:4] == 2'h1); e[8] = 1'b1; e[7:6] = o[3:2]; e[5:4] = o[1:0];
      end
      default: ;
    endcase
    return e;
  endfunction
  function automatic logic [15:0] outs();
    return {pin_oe, pin_o & pin_oe, rail, wpu, wpd, pu18, pu180, asel, tm, mt, 2'b00, dsg, chg};
  endfunction
  task automatic run_case(input logic [7:0] s, input logic drv, input logic ev, input logic en);
    logic [31:0] r;
    logic [15:0] e;
    logic lvl, cf, en_eff;
    e = model(s, drv, 1'b0);
    // Host lets go only where a weak pull defines the wire
    en_eff = en | ~(e[12] | e[11]);
    ext_val <= ev;
    ext_en <= en_eff;
    bus(OFF_PIN_SETUP, 1'b1, {24'h00_0000, s}, r);
    bus(OFF_DRIVE, 1'b1, {31'h0, drv}, r);
    repeat (3) @(posedge clk);
    lvl = (s[1:0] == 2'h1 && e[15]) ? drv : (en_eff ? ev : e[12]);
    e = model(s, drv, lvl);
    e[14] = e[14] & e[15];
    chk({16'h0000, outs()}, {16'h0000, e}, "decoded outputs");
    chk({31'h0, hresp}, 32'h0000_0000, "response");
    bus(OFF_PIN_SETUP, 1'b0, 32'h0000_0000, r);
    chk(r, {24'h00_0000, s}, "setup readback");
    bus(OFF_STATUS, 1'b0, 32'h0000_0000, r);
    cf = (s[1:0] == 2'h1 || s[1:0] == 2'h2) && s[5] && (s[4] || !s[3]);
    chk(r, {25'h0, cf, e[0], e[1], e[1], lvl, s[1:0]}, "status");
  endtask
  initial begin
    logic [31:0] r;
    rst_b = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = '0; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; ext_val = 1'b0; ext_en = 1'b1; seed = 32'h709a;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({16'h0000, outs()}, 32'h0000_0000, "outputs after reset");
    bus(OFF_PIN_SETUP, 1'b0, 32'h0000_0000, r);
    chk(r, 32'h0000_0000, "setup after reset");
    bus(12'h0FC, 1'b1, 32'hFFFF_FFFF, r);
    bus(12'h0FC, 1'b0, 32'h0000_0000, r);
    chk(r, 32'h0000_0000, "unmapped read");
    $display("Test reset and map done");
    foreach (q[i]) run_case(q[i], i[0], i[1], i[2]);
    $display("Test directed settings done");
    repeat (60) begin
      v = $random(seed);
      run_case(v[7:0], v[8], v[9], v[10]);
    end
    $display("Test random settings done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(OFF_PIN_SETUP, 1'b0, 32'h0000_0000, r);
    chk(r, 32'h0000_0000, "setup after second reset");
    $display("Test second reset done");
    report_and_stop();
  end
endmodule // discharge_off_pin_config_tb
